// ### inc/nvm_ctrl_defs.svh
// Register offsets, field positions, reset values and timing counts of the NVM controller.
`ifndef NVM_CTRL_DEFS_SVH
`define NVM_CTRL_DEFS_SVH
`define NVM_OFS_ADDR_HIGH 2'h0
`define NVM_OFS_ADDR_LOW 2'h1
`define NVM_OFS_DATA 2'h2
`define NVM_OFS_CONTROL 2'h3
`define NVM_BIT_READ_STROBE 0
`define NVM_BIT_PROG_GO_BUSY 1
`define NVM_BIT_MASTER_PROG_ARM 2
`define NVM_BIT_READY_IRQ_ENABLE 3
`define NVM_BIT_PROG_MODE_LO 4
`define NVM_BIT_PROG_MODE_HI 5
`define NVM_MODE_RESET 2'h0
`define NVM_CLK_HZ 20000000
`define NVM_T_ATOMIC_US 3400
`define NVM_T_SPLIT_US 1800
`define NVM_ARM_CYCLES 4
`define NVM_PROG_STALL_CYCLES 2
`define NVM_READ_STALL_CYCLES 4
`endif

// ### inc/nvm_ctrl_pkg.sv
// Types shared by the NVM controller modules.
package nvm_ctrl_pkg;
  typedef enum logic [1:0] {
    mode_atomic = 2'b00,
    mode_erase = 2'b01,
    mode_write = 2'b10,
    mode_reserved = 2'b11
  } prog_mode_t;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_prog = 2'b01
  } prog_state_t;
endpackage

// ### rtl/nvm_stall_timer.sv
// Down-counter that holds the CPU stall request for a loaded number of cycles.
`timescale 1ns/1ps
`default_nettype none
module nvm_stall_timer #(
  parameter int W = 3
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Load request
  input wire logic i_load,
  input wire logic [W-1:0] i_count,
  // Stall output
  output logic o_stall
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  if (W < 1)
  begin : g_bad_w
    $error("W must be at least 1");
  end
  always_comb
  begin
    next_count = count;
    if (i_load)
    begin
      next_count = i_count;
    end
    else if (count != '0)
    begin
      next_count = count - W'(1);
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      count <= '0;
    end
    else
    begin
      count <= next_count;
    end
  end
  assign o_stall = (count != '0);
endmodule
`default_nettype wire

// ### rtl/nvm_byte_array.sv
// Byte storage array standing in for the nonvolatile cells, with erase and write.
`timescale 1ns/1ps
`default_nettype none
module nvm_byte_array #(
  parameter int AW = 9
) (
  // Clock
  input wire logic i_clk,
  // Access
  input wire logic [AW-1:0] i_addr,
  input wire logic i_erase,
  input wire logic i_write,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:(1<<AW)-1];
  if (AW < 1 || AW > 16)
  begin : g_bad_aw
    $error("AW must lie between 1 and 16");
  end
  // Erased cells read all ones; a write-only clears bits, as real cells do.
  always_ff @(posedge i_clk)
  begin
    if (i_erase && i_write)
    begin
      mem[i_addr] <= i_wdata;
    end
    else if (i_erase)
    begin
      mem[i_addr] <= 8'hff;
    end
    else if (i_write)
    begin
      mem[i_addr] <= mem[i_addr] & i_wdata;
    end
  end
  assign o_rdata = mem[i_addr];
endmodule
`default_nettype wire

// ### rtl/nvm_access_ctrl.sv
// Register-level access controller for the on-chip data NVM.
// What this block does
// - Reserved upper bits of high address and control registers read zero.
// - Bytes addressed linearly from zero to size minus one, 256 or 512.
// - Address bits beyond the memory size are read-only and read zero.
// - Data register holds write byte, and fetched byte after a read strobe.
// - Mode 00 atomic 3.4 ms, 01 erase 1.8 ms, 10 write 1.8 ms, 11 reserved.
// - Mode writes are ignored while the busy flag is set.
// - System reset returns mode to 00 unless programming is in progress.
// - Ready interrupt requested when enabled, global enable set, memory ready.
// - Hardware clears master arm four cycles after software sets it.
// - Program go starts programming only within four cycles of arming.
// - CPU stalled two cycles after program go is set.
// - Busy flag stays set for the programming time, then clears.
// - Running programming blocks software flash, fuse and lock programming.
// - Read strobe fetches byte at once and stalls CPU four cycles, two if an armed program go comes with it.
// - No reads and no address changes while programming runs.
// - Started programming runs to completion even across system reset.
`timescale 1ns/1ps
`default_nettype none
`include "nvm_ctrl_defs.svh"
module nvm_access_ctrl #(
  parameter int ADDR_BITS = 9,
  parameter int ATOMIC_CYCLES = (`NVM_T_ATOMIC_US * (`NVM_CLK_HZ / 1000000)),
  parameter int SPLIT_CYCLES = (`NVM_T_SPLIT_US * (`NVM_CLK_HZ / 1000000))
) (
  // Clock and resets; i_por_rstn is power-on only, i_rstn is system reset
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_por_rstn,
  // Register port
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Core side
  input wire logic i_global_irq_enable,
  output logic o_ready_irq,
  output logic o_cpu_stall,
  output logic o_block_self_prog
);
  localparam int CW = 18;

  // The program counter is CW bits wide, so cycle counts that do not fit it are rejected with an error at elaboration.
  if (ADDR_BITS != 8 && ADDR_BITS != 9)
  begin : g_bad_addr_bits
    $error("ADDR_BITS must be 8 or 9");
  end
  if (ATOMIC_CYCLES < 1 || ATOMIC_CYCLES >= (1 << CW) || SPLIT_CYCLES < 1 ||
    SPLIT_CYCLES >= (1 << CW))
  begin : g_bad_cycles
    $error("program cycle counts must fit the program counter");
  end

  // Programming state lives on the power-on reset so a system reset cannot abort it.
  nvm_ctrl_pkg::prog_state_t state;
  nvm_ctrl_pkg::prog_state_t next_state;
  logic [CW-1:0] prog_cnt;
  logic [CW-1:0] next_prog_cnt;
  logic [1:0] mode;
  logic [1:0] next_mode;
  logic prog_erase;
  logic prog_write;
  logic next_prog_erase;
  logic next_prog_write;
  logic [ADDR_BITS-1:0] prog_addr;
  logic [ADDR_BITS-1:0] next_prog_addr;
  logic [7:0] prog_data;
  logic [7:0] next_prog_data;

  // Software-visible state on the system reset.
  logic [8:0] addr;
  logic [8:0] next_addr;
  logic [7:0] data;
  logic [7:0] next_data;
  logic irq_en;
  logic next_irq_en;
  logic [2:0] arm_cnt;
  logic [2:0] next_arm_cnt;
  logic [7:0] rdata;
  logic [7:0] next_rdata;

  logic busy;
  logic wr_ctrl;
  logic go_req;
  logic start;
  logic read_req;
  logic [7:0] cell_rdata;
  logic [8:0] addr_mask;
  logic mem_erase;
  logic mem_write;
  logic [ADDR_BITS-1:0] cell_addr;

  assign busy = (state == nvm_ctrl_pkg::st_prog);
  assign addr_mask = (ADDR_BITS == 9) ? 9'h1ff : 9'h0ff;
  assign wr_ctrl = i_wr && (i_addr == `NVM_OFS_CONTROL);
  assign go_req = wr_ctrl && i_wdata[`NVM_BIT_PROG_GO_BUSY];
  assign start = go_req && !busy && (arm_cnt != 3'h0);
  assign read_req = wr_ctrl && i_wdata[`NVM_BIT_READ_STROBE] && !busy;
  assign mem_erase = busy && (prog_cnt == CW'(1)) && prog_erase;
  assign mem_write = busy && (prog_cnt == CW'(1)) && prog_write;
  assign cell_addr = busy ? prog_addr : addr[ADDR_BITS-1:0];

  nvm_byte_array #(
    .AW(ADDR_BITS)
  ) u_array (
    .i_clk(i_clk),
    .i_addr(cell_addr),
    .i_erase(mem_erase),
    .i_write(mem_write),
    .i_wdata(prog_data),
    .o_rdata(cell_rdata)
  );

  // Programming engine.
  always_comb
  begin
    next_state = state;
    next_prog_cnt = prog_cnt;
    next_mode = mode;
    next_prog_erase = prog_erase;
    next_prog_write = prog_write;
    next_prog_addr = prog_addr;
    next_prog_data = prog_data;
    unique case (state)
      nvm_ctrl_pkg::st_idle:
      begin
        if (wr_ctrl)
        begin
          next_mode = i_wdata[`NVM_BIT_PROG_MODE_HI:`NVM_BIT_PROG_MODE_LO];
        end
        if (start)
        begin
          // Target and byte are captured so that a system reset, which clears the
          // software registers, cannot redirect a burn that is already under way.
          next_prog_erase = (mode != 2'(nvm_ctrl_pkg::mode_write));
          next_prog_write = (mode != 2'(nvm_ctrl_pkg::mode_erase));
          next_prog_addr = addr[ADDR_BITS-1:0];
          next_prog_data = data;
        end
        if (start && mode != 2'(nvm_ctrl_pkg::mode_reserved))
        begin
          next_state = nvm_ctrl_pkg::st_prog;
          next_prog_cnt = (mode == 2'(nvm_ctrl_pkg::mode_atomic)) ?
            CW'(ATOMIC_CYCLES) : CW'(SPLIT_CYCLES);
        end
      end
      nvm_ctrl_pkg::st_prog:
      begin
        // Mode writes dropped while busy.
        next_prog_cnt = prog_cnt - CW'(1);
        if (prog_cnt == CW'(1))
        begin
          next_state = nvm_ctrl_pkg::st_idle;
        end
      end
    endcase
    // System reset clears mode only when idle; busy work survives it.
    if (!i_rstn && !busy)
    begin
      next_mode = `NVM_MODE_RESET;
    end
  end

  always_ff @(posedge i_clk or negedge i_por_rstn)
  begin
    if (!i_por_rstn)
    begin
      state <= nvm_ctrl_pkg::st_idle;
      prog_cnt <= '0;
      mode <= `NVM_MODE_RESET;
      prog_erase <= 1'b0;
      prog_write <= 1'b0;
      prog_addr <= '0;
      prog_data <= 8'h00;
    end
    else
    begin
      state <= next_state;
      prog_cnt <= next_prog_cnt;
      mode <= next_mode;
      prog_erase <= next_prog_erase;
      prog_write <= next_prog_write;
      prog_addr <= next_prog_addr;
      prog_data <= next_prog_data;
    end
  end

  // Registers and arming window.
  always_comb
  begin
    next_addr = addr;
    next_data = data;
    next_irq_en = irq_en;
    next_arm_cnt = arm_cnt;
    next_rdata = 8'h00;
    if (arm_cnt != 3'h0)
    begin
      next_arm_cnt = arm_cnt - 3'h1;
    end
    if (i_wr && !busy && i_addr == `NVM_OFS_ADDR_HIGH)
    begin
      next_addr = {i_wdata[0], addr[7:0]} & addr_mask;
    end
    if (i_wr && !busy && i_addr == `NVM_OFS_ADDR_LOW)
    begin
      next_addr = {addr[8], i_wdata} & addr_mask;
    end
    if (i_wr && i_addr == `NVM_OFS_DATA)
    begin
      next_data = i_wdata;
    end
    if (wr_ctrl)
    begin
      next_irq_en = i_wdata[`NVM_BIT_READY_IRQ_ENABLE];
      if (i_wdata[`NVM_BIT_MASTER_PROG_ARM])
      begin
        next_arm_cnt = 3'(`NVM_ARM_CYCLES);
      end
      if (start)
      begin
        next_arm_cnt = 3'h0;
      end
    end
    if (read_req)
    begin
      next_data = cell_rdata;
    end
    if (i_rd)
    begin
      unique case (i_addr)
        `NVM_OFS_ADDR_HIGH: next_rdata = {7'h00, addr[8]};
        `NVM_OFS_ADDR_LOW: next_rdata = addr[7:0];
        `NVM_OFS_DATA: next_rdata = data;
        `NVM_OFS_CONTROL: next_rdata = {2'b00, mode, irq_en, (arm_cnt != 3'h0), busy,
          1'b0};
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      addr <= 9'h000;
      data <= 8'h00;
      irq_en <= 1'b0;
      arm_cnt <= 3'h0;
      rdata <= 8'h00;
    end
    else
    begin
      addr <= next_addr;
      data <= next_data;
      irq_en <= next_irq_en;
      arm_cnt <= next_arm_cnt;
      rdata <= next_rdata;
    end
  end

  nvm_stall_timer #(
    .W(3)
  ) u_stall (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_load(start || read_req),
    .i_count(start ? 3'(`NVM_PROG_STALL_CYCLES) : 3'(`NVM_READ_STALL_CYCLES)),
    .o_stall(o_cpu_stall)
  );

  assign o_rdata = rdata;
  assign o_ready_irq = irq_en && i_global_irq_enable && !busy;
  assign o_block_self_prog = busy;

  a_arm_expires: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (wr_ctrl && i_wdata[`NVM_BIT_MASTER_PROG_ARM] && !start) ##1 (!wr_ctrl) [*4] |->
    (arm_cnt == 3'h1) ##1 (arm_cnt == 3'h0))
    else $error("master arm not cleared after four cycles");
  a_go_needs_arm: assert property (@(posedge i_clk) disable iff (!i_por_rstn)
    (go_req && arm_cnt == 3'h0 && !busy) |=> !busy)
    else $error("programming started without arming");
  a_prog_stall: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (start) |=> o_cpu_stall [*2] ##1 !o_cpu_stall)
    else $error("program stall not two cycles");
  a_read_stall: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (read_req && !start) |=> o_cpu_stall [*4] ##1 !o_cpu_stall)
    else $error("read stall not four cycles");
  a_read_data: assert property (@(posedge i_clk) disable iff (!i_rstn)
    read_req |=> data == $past(cell_rdata))
    else $error("read strobe did not load data");
  a_mode_frozen: assert property (@(posedge i_clk) disable iff (!i_por_rstn)
    (busy && $past(busy)) |-> $stable(mode))
    else $error("mode changed while busy");
  a_addr_frozen: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (busy && i_wr && i_addr != `NVM_OFS_DATA && i_addr != `NVM_OFS_CONTROL)
    |=> $stable(addr))
    else $error("address changed while busy");
  a_irq_level: assert property (@(posedge i_clk) disable iff (!i_rstn)
    busy |-> !o_ready_irq)
    else $error("ready interrupt while busy");
  a_busy_set: assert property (@(posedge i_clk) disable iff (!i_por_rstn)
    (start && mode != 2'b11) |=> busy [*8])
    else $error("busy dropped early");
endmodule
`default_nettype wire

// ### tb/nvm_cpu_model.sv
// Processor-side bus master that issues register writes and reads.
`timescale 1ns/1ps
`default_nettype none
module nvm_cpu_model (
  // Clock
  input wire logic i_clk,
  // Register port toward the controller
  output logic [1:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd,
  input wire logic [7:0] i_rdata
);
  initial
  begin
    o_addr = 2'h0;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // Released write data is inverted so a stale byte can never pass as fresh.
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask
endmodule
`default_nettype wire

// ### tb/nvm_access_ctrl_tb_top.sv
// Self-checking bench for the NVM access controller.
`timescale 1ns/1ps
`default_nettype none
`include "nvm_ctrl_defs.svh"
`define CHK(g, e) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("[ERR] %0t got %h expected %h", $time, (g), (e)); \
    end \
  end
module nvm_access_ctrl_tb_top;
  // Short program times keep the run brief; erase still outlasts the probe.
  localparam int ATOM = 40;
  localparam int SPLIT = 24;
  logic clk;
  logic rstn;
  logic por_rstn;
  logic gie;
  logic ie;
  logic [1:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic irq;
  logic stall;
  logic blk;
  logic [31:0] seed;
  logic [8:0] a;
  logic [7:0] q;
  int error_cnt;
  int compares;
  int cycles;
  int ns;
  int nb;
  nvm_access_ctrl #(.ATOMIC_CYCLES(ATOM), .SPLIT_CYCLES(SPLIT)) nvm_access_ctrl_i (
    .i_clk(clk), .i_rstn(rstn), .i_por_rstn(por_rstn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_global_irq_enable(gie), .o_ready_irq(irq),
    .o_cpu_stall(stall), .o_block_self_prog(blk));
  nvm_cpu_model nvm_cpu_model_i (
    .i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd), .i_rdata(rdata));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic int prog_len(input logic [1:0] m);
    return (m == 2'b00) ? ATOM : SPLIT;
  endfunction
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      $display("[ERR] %0t timeout", $time);
      tally_and_finish();
    end
  end
  task automatic measure();
    ns = 0;
    nb = 0;
    for (int k = 0; k < 100; k++)
    begin
      #1;
      ns += (stall === 1'b1);
      nb += (blk === 1'b1);
      if (stall !== 1'b1 && blk !== 1'b1)
        break;
      @(posedge clk);
    end
  endtask
  task automatic set_addr(input logic [8:0] x);
    nvm_cpu_model_i.wr(`NVM_OFS_ADDR_HIGH, {7'h00, x[8]});
    nvm_cpu_model_i.wr(`NVM_OFS_ADDR_LOW, x[7:0]);
  endtask
  task automatic rd_cell(input logic [8:0] x, input logic [7:0] e);
    q = 8'h02;
    while (q[`NVM_BIT_PROG_GO_BUSY] !== 1'b0)
      nvm_cpu_model_i.rd(`NVM_OFS_CONTROL, q);
    set_addr(x);
    nvm_cpu_model_i.wr(`NVM_OFS_CONTROL, 8'h01);
    measure();
    `CHK(ns, `NVM_READ_STALL_CYCLES)
    nvm_cpu_model_i.rd(`NVM_OFS_DATA, q);
    `CHK(q, e)
  endtask
  task automatic prog(input logic [1:0] m, input logic [8:0] x, input logic [7:0] d, input bit p);
    set_addr(x);
    nvm_cpu_model_i.wr(`NVM_OFS_DATA, d);
    nvm_cpu_model_i.wr(`NVM_OFS_CONTROL, {2'b00, m, ie, 3'b100});
    #1;
    `CHK(irq, ie & gie)
    nvm_cpu_model_i.wr(`NVM_OFS_CONTROL, {2'b00, m, ie, 3'b010});
    if (p)
    begin
      #1;
      `CHK(irq, 1'b0)
      nvm_cpu_model_i.wr(`NVM_OFS_CONTROL, 8'h30);
      nvm_cpu_model_i.wr(`NVM_OFS_ADDR_LOW, ~x[7:0]);
      nvm_cpu_model_i.rd(`NVM_OFS_ADDR_LOW, q);
      `CHK(q, x[7:0])
      @(posedge clk);
      rstn <= 1'b0;
      @(posedge clk);
      rstn <= 1'b1;
      nvm_cpu_model_i.rd(`NVM_OFS_CONTROL, q);
      `CHK(q, {2'b00, m, 4'b0010})
    end
    measure();
    if (!p)
    begin
      `CHK(ns, `NVM_PROG_STALL_CYCLES)
      `CHK(nb, prog_len(m))
    end
  endtask
  initial
  begin
    rstn = 1'b0;
    por_rstn = 1'b0;
    gie = 1'b0;
    ie = 1'b0;
    seed = 32'h0000_d0df;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    por_rstn <= 1'b1;
    nvm_cpu_model_i.rd(`NVM_OFS_CONTROL, q);
    `CHK(q, 8'h00)
    nvm_cpu_model_i.wr(`NVM_OFS_ADDR_HIGH, 8'hff);
    nvm_cpu_model_i.rd(`NVM_OFS_ADDR_HIGH, q);
    `CHK(q, 8'h01)
    nvm_cpu_model_i.wr(`NVM_OFS_CONTROL, 8'h04);
    nvm_cpu_model_i.rd(`NVM_OFS_CONTROL, q);
    `CHK(q, 8'h04)
    repeat (3) @(posedge clk);
    nvm_cpu_model_i.rd(`NVM_OFS_CONTROL, q);
    `CHK(q, 8'h00)
    nvm_cpu_model_i.wr(`NVM_OFS_CONTROL, 8'h02);
    measure();
    `CHK(nb, 0)
    nvm_cpu_model_i.wr(`NVM_OFS_CONTROL, 8'h34);
    nvm_cpu_model_i.wr(`NVM_OFS_CONTROL, 8'h32);
    measure();
    `CHK(nb, 0)
    $display("test arming done");
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      a = (i == 0) ? 9'h1ff : (i == 1) ? 9'h000 : seed[8:0];
      ie = seed[26];
      @(posedge clk);
      gie <= seed[25];
      prog(2'b00, a, seed[16:9], 1'b0);
      rd_cell(a, seed[16:9]);
      prog(2'b01, a, seed[16:9], 1'b0);
      rd_cell(a, 8'hff);
      prog(2'b10, a, seed[24:17], 1'b0);
      rd_cell(a, seed[24:17]);
      $display("test cell %0d done", i);
    end
    prog(2'b01, a, 8'h00, 1'b1);
    rd_cell(a, 8'hff);
    $display("test busy probe done");
    nvm_cpu_model_i.wr(`NVM_OFS_CONTROL, 8'h20);
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    nvm_cpu_model_i.rd(`NVM_OFS_CONTROL, q);
    `CHK(q, 8'h00)
    $display("test idle reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
